// File: common/itt_pkg.sv
// Shared constants and types of the imaging transport target core
package itt_pkg;
   // ==========================================================
   // Payload limits
   localparam int          LEN_W    = 21;
   localparam logic [20:0] MAX_PAY  = 21'h100000;  // 2^20 bytes
   localparam int          UNIT_SH  = 7;           // 128-byte units
   // ==========================================================
   // Timing
   localparam int          CLK_HZ   = 10_000_000;
   localparam int          TICK_MS  = 1000;        // one second tick
   localparam int          TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam logic [8:0]  ART_MAX_S = 9'h12C;     // 300 s ceiling
   // ==========================================================
   // Request kinds and management functions
   localparam logic [2:0]  K_DIN  = 3'h0;
   localparam logic [2:0]  K_DOUT = 3'h1;
   localparam logic [2:0]  K_SCMD = 3'h2;
   localparam logic [2:0]  K_SCTL = 3'h3;
   localparam logic [2:0]  K_MGMT = 3'h4;
   localparam logic [3:0]  F_LOGIN = 4'h0;
   localparam logic [3:0]  F_QUERY = 4'h1;
   localparam logic [3:0]  F_CSTRM = 4'h2;
   localparam logic [3:0]  F_RECON = 4'h3;
   localparam logic [3:0]  F_SETPW = 4'h4;
   localparam logic [3:0]  F_LOGOUT = 4'h7;
   localparam logic [3:0]  F_NOTSUP = 4'hA;
   localparam logic [3:0]  F_ABT    = 4'hB;
   localparam logic [3:0]  F_ABTSET = 4'hC;
   localparam logic [3:0]  F_CLRSET = 4'hD;
   localparam logic [3:0]  F_LURST  = 4'hE;
   localparam logic [3:0]  F_TGTRST = 4'hF;
   // ==========================================================
   // Status codes
   localparam logic [1:0]  SMFT_NORM  = 2'h0;
   localparam logic [1:0]  SMFT_UNSOL = 2'h3;
   localparam logic [1:0]  RESP_DONE  = 2'h0;
   localparam logic [7:0]  SBP_OK     = 8'h00;
   localparam logic [7:0]  SBP_UNSUP  = 8'h01;
   localparam logic [7:0]  SBP_RSRC   = 8'h04;
   localparam logic [7:0]  SBP_BADID  = 8'h0A;
   localparam logic [7:0]  SBP_LENERR = 8'hFF;
   localparam logic [4:0]  LEN_STS    = 5'h04;
   localparam logic [4:0]  LEN_LOGIN  = 5'h10;     // 12 + appended quad
   // ==========================================================
   // Register map and reset values
   localparam logic [7:0]  A_CTRL = 8'h00;
   localparam logic [7:0]  A_SUPT = 8'h04;
   localparam logic [7:0]  A_SUPP = 8'h08;
   localparam logic [7:0]  A_STAT = 8'h0C;
   localparam logic [7:0]  A_NEG  = 8'h10;
   localparam logic [8:0]  R_SUP_ART  = 9'h12C;
   localparam logic [6:0]  R_SUP_NTAT = 7'h0A;
   localparam logic [7:0]  R_SUP_PAY  = 8'h80;
   localparam logic [1:0]  AXI_OKAY   = 2'h0;
   localparam logic [1:0]  AXI_SLVERR = 2'h2;
   // ==========================================================
   // State types
   typedef enum logic [1:0] {S_FREE, S_ACT, S_HOLD, S_PING} itt_sess_t;
   typedef enum logic [1:0] {C_IDLE, C_XFER, C_STS} itt_cmd_t;
endpackage : itt_pkg

// File: core/itt_core.sv
// Imaging transport target: transfers, management, session timers
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module itt_core #(
   parameter int TICK_CYCLES = itt_pkg::TICK_CYC
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // AXI4-Lite register slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Request blocks from the fetch agent
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [2:0]  req_kind,
   input  wire logic [3:0]  req_func,
   input  wire logic [20:0] req_len,
   input  wire logic        req_oob,
   input  wire logic [31:0] req_param,
   // Status blocks to the initiator
   output logic             sts_valid,
   input  wire logic        sts_ready,
   output logic [31:0]      sts_word,
   output logic [1:0]       sts_resp,
   output logic [7:0]       sts_sbp,
   output logic [4:0]       sts_len,
   output logic             cmd_done,
   // Payload mover
   output logic             xfer_start,
   output logic             xfer_dir_in,
   output logic [20:0]      xfer_len,
   input  wire logic        xfer_done,
   // Transport client and link events
   input  wire logic [20:0] avail_len,
   input  wire logic        avail_oob,
   input  wire logic        bus_reset,
   input  wire logic        credit_grant,
   output logic             session_open
);
   // ==========================================================
   // State
   typedef struct packed {
      itt_pkg::itt_sess_t sess;
      itt_pkg::itt_cmd_t  cmd;
      logic [8:0]  art;
      logic [6:0]  ntat;
      logic [7:0]  i2t;
      logic [7:0]  t2i;
      logic [8:0]  sup_art;
      logic [6:0]  sup_ntat;
      logic [7:0]  sup_i2t;
      logic [7:0]  sup_t2i;
      logic        pkt_mode;
      logic [23:0] pre;
      logic [8:0]  sec;
      logic        credit;
      logic        ping;
      logic        xin;
      logic        xoob;
      logic        start;
      logic [20:0] xlen;
      logic        svalid;
      logic [31:0] sword;
      logic [1:0]  sresp;
      logic [7:0]  ssbp;
      logic [4:0]  slen;
      logic        aw_ok;
      logic [7:0]  aw_adr;
      logic        w_ok;
      logic [31:0] w_dat;
      logic [3:0]  w_stb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } itt_state_t;

   itt_state_t q;
   itt_state_t d;

   function automatic logic [20:0] mn(logic [20:0] a, logic [20:0] b);
      mn = (a < b) ? a : b;
   endfunction : mn

   function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                         logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      merge = (o & ~m) | (n & m);
   endfunction : merge

   // ==========================================================
   // Combinational helpers
   logic        act;
   logic        tick;
   logic        expire;
   logic [8:0]  lim;
   logic [20:0] cap_in;
   logic [20:0] cap_out;
   logic [20:0] din_len;
   logic        dav;
   logic [31:0] neg_q;
   logic [31:0] ctl_img;
   logic [31:0] supt_img;
   logic [31:0] supp_img;
   logic [31:0] wv;
   logic        take;
   logic        credit_use;

   assign act     = (q.sess == itt_pkg::S_ACT) || (q.sess == itt_pkg::S_PING);
   assign dav     = (avail_len != 21'h000000);
   assign cap_in  = {6'h00, q.t2i, 7'h00};
   assign cap_out = {6'h00, q.i2t, 7'h00};
   assign neg_q   = {q.art[7:0], q.ntat, q.art[8], q.i2t, q.t2i};
   assign ctl_img = {31'h0, q.pkt_mode};
   assign supt_img = {9'h0, q.sup_ntat, 7'h0, q.sup_art};
   assign supp_img = {16'h0, q.sup_t2i, q.sup_i2t};
   assign take    = req_valid && req_ready;
   // Packet mode moves the one packet held, cut to cap_in and MAX_PAY; request size ignored
   assign din_len = mn(mn(q.pkt_mode ? avail_len : mn(req_len, avail_len),
                          cap_in), itt_pkg::MAX_PAY);
   // Timers only run while a session is parked or pinged
   assign tick   = (q.pre == 24'(TICK_CYCLES - 1));
   assign lim    = (q.sess == itt_pkg::S_HOLD) ? q.art : {2'h0, q.ntat};
   assign expire = tick && ((q.sec + 9'h001) >= lim);

   // Handshake outputs
   assign req_ready     = (q.cmd == itt_pkg::C_IDLE) && !(q.ping && act);
   assign cmd_done      = q.svalid && sts_ready;
   assign s_axi_awready = !q.aw_ok && !q.bvalid;
   assign s_axi_wready  = !q.w_ok && !q.bvalid;
   assign s_axi_arready = !q.rvalid;

   // Registered outputs
   assign sts_valid    = q.svalid;
   assign sts_word     = q.sword;
   assign sts_resp     = q.sresp;
   assign sts_sbp      = q.ssbp;
   assign sts_len      = q.slen;
   assign xfer_start   = q.start;
   assign xfer_dir_in  = q.xin;
   assign xfer_len     = q.xlen;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp  = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp  = q.rresp;
   assign s_axi_rdata  = q.rdata;
   assign session_open = (q.sess != itt_pkg::S_FREE);

   // ==========================================================
   // Next state
   always_comb begin
      d = q;
      d.start = 1'b0;
      credit_use = 1'b0;
      wv = 32'h0;
      // Register writes: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_ok  = 1'b1;
         d.aw_adr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_ok  = 1'b1;
         d.w_dat = s_axi_wdata;
         d.w_stb = s_axi_wstrb;
      end
      if (q.aw_ok && q.w_ok) begin
         d.aw_ok  = 1'b0;
         d.w_ok   = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = itt_pkg::AXI_OKAY;
         unique case (q.aw_adr)
            itt_pkg::A_CTRL: begin
               wv = merge(ctl_img, q.w_dat, q.w_stb);
               d.pkt_mode = wv[0];
               // Ping request is write-one, honoured only in session
               if (q.w_stb[0] && q.w_dat[1] && act) d.ping = 1'b1;
            end
            itt_pkg::A_SUPT: begin
               wv = merge(supt_img, q.w_dat, q.w_stb);
               d.sup_art  = wv[8:0];
               d.sup_ntat = wv[22:16];
            end
            itt_pkg::A_SUPP: begin
               wv = merge(supp_img, q.w_dat, q.w_stb);
               d.sup_i2t = wv[7:0];
               d.sup_t2i = wv[15:8];
            end
            itt_pkg::A_STAT, itt_pkg::A_NEG: ;
            default: d.bresp = itt_pkg::AXI_SLVERR;
         endcase
      end
      if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
      // Register reads
      if (s_axi_arvalid && s_axi_arready) begin
         d.rvalid = 1'b1;
         d.rresp  = itt_pkg::AXI_OKAY;
         unique case (s_axi_araddr)
            itt_pkg::A_CTRL: d.rdata = ctl_img;
            itt_pkg::A_SUPT: d.rdata = supt_img;
            itt_pkg::A_SUPP: d.rdata = supp_img;
            itt_pkg::A_STAT: d.rdata = {18'h0, q.sec, q.ping, q.credit,
                                        dav, q.sess};
            itt_pkg::A_NEG:  d.rdata = neg_q;
            default: begin
               d.rdata = 32'h0;
               d.rresp = itt_pkg::AXI_SLVERR;
            end
         endcase
      end
      if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;

      // Session timer: prescaler plus seconds counter
      if (q.sess == itt_pkg::S_HOLD || q.sess == itt_pkg::S_PING) begin
         d.pre = tick ? 24'h000000 : q.pre + 24'h000001;
         if (tick) d.sec = q.sec + 9'h001;
      end else begin
         d.pre = 24'h000000;
         d.sec = 9'h000;
      end
      if (expire) begin
         d.sess = itt_pkg::S_FREE;
         d.ping = 1'b0;
      end
      // A fresh credit answers the ping
      if (q.sess == itt_pkg::S_PING && credit_grant && !expire)
         d.sess = itt_pkg::S_ACT;
      // Link drop parks the session with its context intact
      if (bus_reset && act) begin
         d.sess = itt_pkg::S_HOLD;
         d.pre  = 24'h000000;
         d.sec  = 9'h000;
      end

      // Command engine
      unique case (q.cmd)
         itt_pkg::C_IDLE: begin
            d.sresp = itt_pkg::RESP_DONE;
            d.ssbp  = itt_pkg::SBP_OK;
            d.slen  = itt_pkg::LEN_STS;
            d.sword = {itt_pkg::SMFT_NORM, dav, 29'h0};
            if (take) begin
               d.cmd    = itt_pkg::C_STS;
               d.svalid = 1'b1;
               if (req_kind == itt_pkg::K_DIN ||
                   req_kind == itt_pkg::K_DOUT) begin
                  d.xin  = (req_kind == itt_pkg::K_DIN);
                  // The request's own out-of-band bit plays no part
                  d.xoob = (req_kind == itt_pkg::K_DIN) && avail_oob;
                  d.xlen = (req_kind == itt_pkg::K_DIN) ? din_len
                                                        : req_len;
                  if (!act) begin
                     d.ssbp = itt_pkg::SBP_BADID;
                  end else if (req_kind == itt_pkg::K_DOUT &&
                               (req_len > cap_out ||
                                req_len > itt_pkg::MAX_PAY)) begin
                     d.ssbp = itt_pkg::SBP_LENERR;
                  end else begin
                     d.start  = 1'b1;
                     d.svalid = 1'b0;
                     d.cmd    = itt_pkg::C_XFER;
                  end
               end else if (req_kind == itt_pkg::K_MGMT) begin
                  unique case (req_func)
                     itt_pkg::F_LOGIN: begin
                        if (q.sess == itt_pkg::S_FREE) begin
                           d.art  = 9'(mn(mn(21'(req_param[31:23]),
                                 21'(q.sup_art)), 21'(itt_pkg::ART_MAX_S)));
                           d.ntat = 7'(mn(21'(req_param[22:16]),
                                          21'(q.sup_ntat)));
                           d.i2t  = 8'(mn(21'(req_param[15:8]),
                                          21'(q.sup_i2t)));
                           d.t2i  = 8'(mn(21'(req_param[7:0]),
                                          21'(q.sup_t2i)));
                           d.sess = itt_pkg::S_ACT;
                        end else if (q.sess == itt_pkg::S_HOLD) begin
                           // Resumed access stops and clears the timer
                           d.sess = itt_pkg::S_ACT;
                           d.pre  = 24'h000000;
                           d.sec  = 9'h000;
                        end else begin
                           d.ssbp = itt_pkg::SBP_RSRC;
                        end
                        d.slen  = itt_pkg::LEN_LOGIN;
                        // Answer with the values just agreed, not old ones
                        d.sword = {d.art[7:0], d.ntat, d.art[8],
                                   d.i2t, d.t2i};
                     end
                     itt_pkg::F_QUERY: d.sword = neg_q;
                     itt_pkg::F_RECON: begin
                        if (q.sess == itt_pkg::S_FREE)
                           d.ssbp = itt_pkg::SBP_BADID;
                        else if (q.sess == itt_pkg::S_HOLD) begin
                           d.sess = itt_pkg::S_ACT;
                           d.pre  = 24'h000000;
                           d.sec  = 9'h000;
                        end
                     end
                     itt_pkg::F_LOGOUT, itt_pkg::F_TGTRST: begin
                        d.sess = itt_pkg::S_FREE;
                        d.ping = 1'b0;
                        d.credit = 1'b0;
                     end
                     itt_pkg::F_NOTSUP, itt_pkg::F_ABT,
                     itt_pkg::F_ABTSET, itt_pkg::F_LURST: ;
                     default: d.ssbp = itt_pkg::SBP_UNSUP;
                  endcase
               end else begin
                  d.ssbp = itt_pkg::SBP_UNSUP;
               end
            end else if (q.ping && act) begin
               // Ping: spend a credit if one is held, else just wait
               d.ping = 1'b0;
               d.sess = itt_pkg::S_PING;
               d.pre  = 24'h000000;
               d.sec  = 9'h000;
               if (q.credit) begin
                  credit_use = 1'b1;
                  d.sword  = {itt_pkg::SMFT_UNSOL, dav, 29'h0};
                  d.svalid = 1'b1;
                  d.cmd    = itt_pkg::C_STS;
               end
            end
         end
         itt_pkg::C_XFER: begin
            if (xfer_done) begin
               d.cmd    = itt_pkg::C_STS;
               d.svalid = 1'b1;
               d.sword  = {itt_pkg::SMFT_NORM, dav, q.xoob,
                           7'h00, q.xin ? q.xlen : 21'h0};
            end
         end
         itt_pkg::C_STS: begin
            if (sts_ready) begin
               d.svalid = 1'b0;
               d.cmd    = itt_pkg::C_IDLE;
            end
         end
         default: d.cmd = itt_pkg::C_IDLE;
      endcase

      // Credit: a grant in the same cycle as a spend is kept
      // A logout above has already dropped the held credit
      d.credit = (d.credit && !credit_use) || credit_grant;
      if (d.sess == itt_pkg::S_FREE) d.ping = 1'b0;
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q          <= '0;
         q.sess     <= itt_pkg::S_FREE;
         q.cmd      <= itt_pkg::C_IDLE;
         q.sup_art  <= itt_pkg::R_SUP_ART;
         q.sup_ntat <= itt_pkg::R_SUP_NTAT;
         q.sup_i2t  <= itt_pkg::R_SUP_PAY;
         q.sup_t2i  <= itt_pkg::R_SUP_PAY;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_xfer_open;
      q.start ##1 (q.cmd == itt_pkg::C_XFER);
   endsequence
   sequence s_xfer_close;
      (q.cmd == itt_pkg::C_XFER) && xfer_done ##1 q.svalid;
   endsequence

   smft_code_a: assert property (sts_valid |->
      sts_word[31:30] == itt_pkg::SMFT_NORM ||
      sts_word[31:30] == itt_pkg::SMFT_UNSOL)
      else $error("reserved status format code");
   no_early_sts_a: assert property (s_xfer_open |-> !sts_valid)
      else $error("status before payload done");
   len_match_a: assert property (s_xfer_close |->
      sts_word[20:0] == (q.xin ? $past(q.xlen) : 21'h0))
      else $error("valid length differs from moved bytes");
   pay_cap_a: assert property (xfer_start |->
      xfer_len <= itt_pkg::MAX_PAY)
      else $error("payload above limit");
   stream_unsup_a: assert property ((take && (req_kind == itt_pkg::K_SCMD
      || req_kind == itt_pkg::K_SCTL)) |=> sts_valid &&
      sts_resp == itt_pkg::RESP_DONE && sts_sbp == itt_pkg::SBP_UNSUP)
      else $error("stream request not answered unsupported");
   mgmt_unsup_a: assert property ((take && req_kind == itt_pkg::K_MGMT &&
      (req_func == itt_pkg::F_CSTRM || req_func == itt_pkg::F_SETPW ||
       req_func == itt_pkg::F_CLRSET)) |=>
      sts_sbp == itt_pkg::SBP_UNSUP)
      else $error("unsupported function answered ok");
   logout_free_a: assert property ((take && req_kind == itt_pkg::K_MGMT
      && req_func == itt_pkg::F_LOGOUT) |=>
      q.sess == itt_pkg::S_FREE)
      else $error("logout did not release session");
   hold_expire_a: assert property ((q.sess == itt_pkg::S_HOLD && expire
      && !take) |=> q.sess == itt_pkg::S_FREE)
      else $error("hold expiry did not release");
   resume_a: assert property ((q.sess == itt_pkg::S_HOLD && take &&
      req_kind == itt_pkg::K_MGMT && req_func == itt_pkg::F_LOGIN &&
      !bus_reset) |=> q.sess == itt_pkg::S_ACT && q.sec == 9'h000)
      else $error("keyed login did not resume");
   ping_end_a: assert property ((q.sess == itt_pkg::S_PING && expire &&
      !take) |=> !session_open)
      else $error("ping timeout did not log out");
   art_cap_a: assert property (q.art <= itt_pkg::ART_MAX_S)
      else $error("resumption timeout above ceiling");
endmodule : itt_core
`default_nettype wire

// File: verification/itt_host_model.sv
// Host model: offers request blocks, takes status, moves payload
`timescale 1ns/1ps
`default_nettype none
module itt_host_model (
   // Clock and design answers
   input  wire logic        sys_clk,
   input  wire logic        req_ready,
   input  wire logic        sts_valid,
   input  wire logic        xfer_start,
   input  wire logic [46:0] sts_all,
   // Request block and status handshake
   output logic             req_valid,
   output logic [2:0]       req_kind,
   output logic [3:0]       req_func,
   output logic [20:0]      req_len,
   output logic             req_oob,
   output logic [31:0]      req_param,
   output logic             sts_ready,
   output logic             xfer_done
);
   // Quiet request side at time zero
   initial {req_valid, req_kind, req_func, req_len, req_oob} = '0;
   initial {req_param, sts_ready, xfer_done} = '0;
   // Buffer always big enough, so payload lands one cycle after start
   always @(posedge sys_clk) xfer_done <= xfer_start;
   // One request in flight; status taken before the next is offered
   task send(input logic [2:0] k, input logic [3:0] f,
             input logic [20:0] l, input logic b, input logic [31:0] p,
             output logic [46:0] r);
      @(posedge sys_clk);
      req_kind  <= k;
      req_func  <= f;
      req_len   <= l;
      req_param <= p;
      req_oob   <= b;
      req_valid <= 1'h1;
      sts_ready <= 1'h1;
      do @(posedge sys_clk); while (req_ready !== 1'h1);
      req_valid <= 1'h0;
      while (sts_valid !== 1'h1) @(posedge sys_clk);
      r = sts_all;
      sts_ready <= 1'h0;
   endtask : send
   // Unsolicited status: ready held until a valid status is sampled
   task take(output logic [46:0] r);
      @(posedge sys_clk);
      sts_ready <= 1'h1;
      do @(posedge sys_clk); while (sts_valid !== 1'h1);
      r = sts_all;
      sts_ready <= 1'h0;
   endtask : take
endmodule : itt_host_model
`default_nettype wire

// File: verification/tb_top.sv
// Testbench: registers, transfers, management and session timers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ====
   // Bench signals
   logic sys_clk = 0, reset = 1, bus_reset = 0, credit_grant = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, avail_oob = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, sts_sbp;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, req_param, sts_word, d;
   logic [3:0]  s_axi_wstrb = 4'hF, req_func;
   logic [20:0] avail_len = 0, req_len, xfer_len;
   logic [1:0]  s_axi_bresp, s_axi_rresp, sts_resp, r;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, req_valid, req_ready, req_oob, sts_valid;
   logic sts_ready, cmd_done, xfer_start, xfer_dir_in, xfer_done;
   logic session_open;
   logic [2:0]  req_kind;
   logic [4:0]  sts_len;
   logic [46:0] o;
   logic [3:0]  uf [3] = '{4'h2, 4'h4, 4'hD};
   int          fails = 0, total_checks = 0, dones = 0;
   // Slow clock, one second tick shortened to 8 cycles
   always #50 sys_clk = ~sys_clk;
   // Completed status writes, one per answered status block
   always @(posedge sys_clk)
      if (cmd_done === 1'h1) dones++;
   itt_core #(.TICK_CYCLES(8)) u_dut (.sys_clk, .reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid,
      .req_ready, .req_kind, .req_func, .req_len, .req_oob, .req_param,
      .sts_valid, .sts_ready, .sts_word, .sts_resp, .sts_sbp, .sts_len,
      .cmd_done, .xfer_start, .xfer_dir_in, .xfer_len, .xfer_done,
      .avail_len, .avail_oob, .bus_reset, .credit_grant, .session_open);
   itt_host_model u_host (.sys_clk, .req_ready, .sts_valid, .xfer_start,
      .sts_all({sts_resp, sts_sbp, sts_len, sts_word}), .req_valid,
      .req_kind, .req_func, .req_len, .req_oob, .req_param, .sts_ready,
      .xfer_done);
   // ====
   // Shared tasks
   task chk(input logic [46:0] g, input logic [46:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt
   // Address and data offered together, each dropped once taken
   task axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : axw
   task axr(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'h0;
   endtask : axr
   task req(input logic [2:0] k, input logic [3:0] f, input logic [20:0] l,
            input logic b, input logic [31:0] p);
      u_host.send(k, f, l, b, p, o);
   endtask : req
   task brst;
      bus_reset <= 1'h1;
      wt(1);
      bus_reset <= 1'h0;
   endtask : brst
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // Watchdog cuts a hang short
   initial begin
      wt(6000);
      fails++;
      report_and_stop();
   end
   // ====
   // Test sequence
   initial begin
      wt(3);
      reset <= 1'h0;
      axr(itt_pkg::A_SUPT);
      chk(47'(d), 47'h000A012C);
      axr(8'h20);
      chk(47'(r), 47'(itt_pkg::AXI_SLVERR));
      axw(8'h20, 32'h0);
      chk(47'(r), 47'(itt_pkg::AXI_SLVERR));
      req(itt_pkg::K_MGMT, itt_pkg::F_LOGIN, 21'h0, 1'h0, 32'hFF850402);
      chk(o, {2'h0, 8'h00, 5'h10, 32'h2C0B0402});
      axr(itt_pkg::A_NEG);
      chk(47'(d), 47'h2C0B0402);
      avail_len <= 21'h200;
      avail_oob <= 1'h1;
      req(itt_pkg::K_DIN, 4'h0, 21'h300, 1'h1, 32'h0);
      chk(47'(o[31:0]), 47'h30000100);
      chk(47'({xfer_dir_in, xfer_len}), 47'h200100);
      axw(itt_pkg::A_CTRL, 32'h1);
      chk(47'(r), 47'(itt_pkg::AXI_OKAY));
      avail_len <= 21'h080;
      avail_oob <= 1'h0;
      req(itt_pkg::K_DIN, 4'h0, 21'h010, 1'h0, 32'h0);
      chk(47'(o[31:0]), 47'h20000080);
      axw(itt_pkg::A_CTRL, 32'h0);
      req(itt_pkg::K_DOUT, 4'h0, 21'h201, 1'h0, 32'h0);
      chk(47'(o[44:37]), 47'hFF);
      req(itt_pkg::K_DOUT, 4'h0, 21'h200, 1'h1, 32'h0);
      chk(47'({o[44:37], o[31:29]}), 47'h001);
      for (int k = 2; k < 4; k++) begin
         req(3'(k), 4'h0, 21'h0, 1'h0, 32'h0);
         chk(47'(o[46:37]), 47'h001);
      end
      for (int i = 0; i < 3; i++) begin
         req(itt_pkg::K_MGMT, uf[i], 21'h0, 1'h0, 32'h0);
         chk(47'(o[44:37]), 47'h01);
      end
      req(itt_pkg::K_MGMT, itt_pkg::F_QUERY, 21'h0, 1'h0, 32'h0);
      chk(47'(o[44:37]), 47'h00);
      req(itt_pkg::K_MGMT, itt_pkg::F_LOGOUT, 21'h0, 1'h0, 32'h0);
      wt(2);
      chk(47'(session_open), 47'h0);
      req(itt_pkg::K_MGMT, itt_pkg::F_LOGIN, 21'h0, 1'h0, 32'h05050402);
      brst();
      wt(60);
      chk(47'(session_open), 47'h1);
      wt(40);
      chk(47'(session_open), 47'h0);
      req(itt_pkg::K_MGMT, itt_pkg::F_LOGIN, 21'h0, 1'h0, 32'h05050402);
      brst();
      wt(40);
      req(itt_pkg::K_MGMT, itt_pkg::F_LOGIN, 21'h0, 1'h0, 32'h05050402);
      wt(90);
      chk(47'(session_open), 47'h1);
      axw(itt_pkg::A_CTRL, 32'h2);
      wt(20);
      chk(47'(session_open), 47'h1);
      wt(50);
      chk(47'(session_open), 47'h0);
      req(itt_pkg::K_MGMT, itt_pkg::F_LOGIN, 21'h0, 1'h0, 32'h05050402);
      credit_grant <= 1'h1;
      wt(1);
      credit_grant <= 1'h0;
      axw(itt_pkg::A_CTRL, 32'h2);
      u_host.take(o);
      chk(47'(o[31:29]), 47'h7);
      wt(20);
      credit_grant <= 1'h1;
      wt(1);
      credit_grant <= 1'h0;
      wt(60);
      chk(47'(session_open), 47'h1);
      chk(47'(dones), 47'h11);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
